// >>> core/ecarb_top.v
/*
 * Exception control arbiter: latches and prioritises peripheral interrupt
 * requests, hands the core a vector select code, handles the software
 * interrupt and break entry, mirrors pending flags in status registers and
 * gates flag clearing in break mode.
 * Assumes the core, the break module and all peripherals run on mclk, and
 * that reset sources are resolved upstream into reset_any and srst.
 */
`timescale 1ns/1ns
`include "ecarb_map.vh"

module ecarb_top (
	input  wire        mclk,         // Bus clock, 100 MHz
	input  wire        srst,         // Synchronous reset, active high
	input  wire [15:0] bus_addr,     // Register address
	input  wire [7:0]  bus_wdata,    // Register write data
	input  wire        bus_wr,       // Write strobe
	input  wire        bus_rd,       // Read strobe
	output reg  [7:0]  bus_rdata,    // Read data, cycle after the strobe
	input  wire [16:0] src_flag,     // Raw peripheral request flags
	input  wire [16:0] src_ie,       // Matching peripheral enable bits
	input  wire        instr_done,   // Core finished an instruction
	input  wire        imask,        // Core interrupt mask bit level
	input  wire        sw_int_exec,  // Core executed the software interrupt
	input  wire        ret_exec,     // Core executed the return instruction
	input  wire        vec_ack,      // Core took the vector and stacked
	input  wire        brk_assert,   // Break module break output
	input  wire        reset_any,    // Some reset source is active
	input  wire [3:0]  clr_step1,    // Two-step clear, first step seen
	input  wire [3:0]  clr_step2,    // Two-step clear, second step seen
	output wire        int_req,      // Asks the core to start an entry
	output reg  [3:0]  vector_sel,   // Vector select constant
	output reg  [15:0] vector_addr,  // First byte of the vector pair
	output reg         push_pc_dec,  // Entry stacks PC minus one
	output wire        push_h,       // Held low: entry never stacks the high index register
	output reg         set_imask,    // Pulse: core sets its mask bit
	output reg         pop_regs,     // Pulse: core unstacks its registers
	output reg         break_mode,   // Core is in the break state
	output wire        clear_permit, // Peripheral flag clears allowed
	output wire [3:0]  clr_fire      // Pulses: two-step clears done
);

	// Arbiter states
	localparam [1:0] ST_IDLE  = 2'b00; // Waiting for an instruction boundary
	localparam [1:0] ST_LATCH = 2'b01; // One request latched, core must take it
	localparam [1:0] ST_RESET = 2'b10; // A reset source holds everything off

	reg  [1:0]  state_q;      // Arbiter state
	reg  [1:0]  state_d;      // Next arbiter state
	reg  [3:0]  lat_vec_q;    // Latched vector code
	reg  [3:0]  lat_vec_d;    // Next latched vector code
	reg         lat_hw_q;     // Latched request came from hardware
	reg         lat_hw_d;     // Next value of lat_hw_q
	reg         lat_brk_q;    // Latched request is a break entry
	reg         lat_brk_d;    // Next value of lat_brk_q
	reg         sw_pend_q;    // Software interrupt waiting to be latched
	reg         imask_q;      // Mask bit one cycle ago
	reg         clr_en_q;     // Clear enable bit of the break flag register
	reg  [11:1] pend;         // Pending flags, one per priority level
	reg  [3:0]  win_vec;      // Highest priority pending hardware code
	reg         win_any;      // Some hardware request is pending
	reg  [7:0]  rd_mux;       // Read data before its output flop
	wire [16:0] src_live;     // Requests whose enables are set
	wire        boundary;     // Instruction boundary seen
	wire        unmasked;     // Falling edge of the mask bit
	integer     i;            // Priority loop index

	// A request counts only while its own enable bit is set
	assign src_live = src_flag & src_ie;

	// The return instruction is itself an instruction boundary, so a
	// request still pending is taken before the interrupted program runs
	assign boundary = instr_done | ret_exec;

	// Mask bit released by software while a request is latched
	assign unmasked = imask_q & ~imask;

	// The high index register is left to the handler to save
	assign push_h = 1'b0;

	// Outside break every clear works; inside, only with clear enable set
	assign clear_permit = ~break_mode | clr_en_q;

	// The core is asked to enter for as long as a request stays latched
	assign int_req = (state_q == ST_LATCH);

	// Group the raw sources into the eleven pending flags
	always @* begin
		pend     = 11'h000;
		pend[1]  = src_live[`ECARB_SRC_EXTPIN];
		pend[2]  = |src_live[`ECARB_SRC_HUB_HI:`ECARB_SRC_HUB_LO];
		pend[3]  = |src_live[`ECARB_SRC_HEP0_HI:`ECARB_SRC_HEP0_LO];
		pend[4]  = |src_live[`ECARB_SRC_DEV_HI:`ECARB_SRC_DEV_LO];
		pend[5]  = src_live[`ECARB_SRC_TCH0];
		pend[6]  = src_live[`ECARB_SRC_TCH1];
		pend[7]  = src_live[`ECARB_SRC_TOVF];
		pend[8]  = src_live[`ECARB_SRC_KEYE];
		pend[9]  = src_live[`ECARB_SRC_KEYD];
		pend[10] = src_live[`ECARB_SRC_KEYF];
		pend[11] = src_live[`ECARB_SRC_PLL];
	end

	// Priority encoder: walk from the lowest priority up so the smallest
	// code, the highest priority, is the one left standing
	always @* begin
		win_vec = 4'h0;
		win_any = 1'b0;
		for (i = `ECARB_NFLAG; i >= 1; i = i - 1) begin
			if (pend[i]) begin
				win_vec = i[3:0];
				win_any = 1'b1;
			end
		end
	end

	// Arbiter next state
	always @* begin
		state_d   = state_q;
		lat_vec_d = lat_vec_q;
		lat_hw_d  = lat_hw_q;
		lat_brk_d = lat_brk_q;
		case (state_q)
			ST_IDLE: begin
				if (reset_any) begin
					// Resets are not arbitrated: they simply win
					state_d = ST_RESET;
				end else if (brk_assert && boundary) begin
					// Break rides on the software interrupt vector
					state_d   = ST_LATCH;
					lat_vec_d = `ECARB_VEC_SOFT;
					lat_hw_d  = 1'b0;
					lat_brk_d = 1'b1;
				end else if (sw_pend_q) begin
					// Software interrupt is taken whatever the mask says
					state_d   = ST_LATCH;
					lat_vec_d = `ECARB_VEC_SOFT;
					lat_hw_d  = 1'b0;
					lat_brk_d = 1'b0;
				end else if (boundary && !imask && win_any) begin
					// Hardware requests only at a boundary, only unmasked
					state_d   = ST_LATCH;
					lat_vec_d = win_vec;
					lat_hw_d  = 1'b1;
					lat_brk_d = 1'b0;
				end
			end
			ST_LATCH: begin
				if (reset_any) begin
					state_d = ST_RESET;
				end else if (vec_ack) begin
					// Serviced: the next boundary arbitrates afresh
					state_d = ST_IDLE;
				end else if (lat_hw_q && unmasked) begin
					// Mask released: drop the latch and arbitrate again
					state_d = ST_IDLE;
				end
				// Any other new request waits, whatever its priority
			end
			ST_RESET: begin
				if (!reset_any) begin
					state_d = ST_IDLE;
				end
			end
			default: begin
				state_d = ST_IDLE;
			end
		endcase
	end

	// Arbiter registers
	always @(posedge mclk) begin
		if (srst) begin
			state_q   <= ST_IDLE;
			lat_vec_q <= `ECARB_VEC_SOFT;
			lat_hw_q  <= 1'b0;
			lat_brk_q <= 1'b0;
			imask_q   <= 1'b1;
		end else begin
			state_q   <= state_d;
			lat_vec_q <= lat_vec_d;
			lat_hw_q  <= lat_hw_d;
			lat_brk_q <= lat_brk_d;
			imask_q   <= imask;
		end
	end

	// Software interrupt request: held until the arbiter latches it, so a
	// strobe arriving while another entry is latched is not lost
	always @(posedge mclk) begin
		if (srst) begin
			sw_pend_q <= 1'b0;
		end else if (reset_any) begin
			sw_pend_q <= 1'b0;
		end else if (sw_int_exec) begin
			sw_pend_q <= 1'b1;
		end else if (state_q == ST_IDLE && state_d == ST_LATCH && !lat_brk_d) begin
			sw_pend_q <= 1'b0;
		end
	end

	// Vector outputs and stacking hints follow the latched request
	always @(posedge mclk) begin
		if (srst) begin
			vector_sel  <= `ECARB_VEC_SOFT;
			vector_addr <= `ECARB_VEC_BASE;
			push_pc_dec <= 1'b0;
		end else begin
			vector_sel  <= lat_vec_d;
			vector_addr <= `ECARB_VEC_BASE - {11'h000, lat_vec_d, 1'b0};
			// Software entry stacks PC itself; hardware stacks PC minus one
			push_pc_dec <= lat_hw_d;
		end
	end

	// Entry and return pulses for the core's stacking sequencer
	always @(posedge mclk) begin
		if (srst) begin
			set_imask <= 1'b0;
			pop_regs  <= 1'b0;
		end else begin
			// Entry: core stacks its registers and sets the mask bit
			set_imask <= (state_q == ST_LATCH) & vec_ack & ~reset_any;
			// Return: core unstacks what the entry saved
			pop_regs  <= ret_exec & ~reset_any;
		end
	end

	// Break state: entered when the break entry is taken, left on return.
	// Nothing is restored to peripheral flags on leaving, so a flag cleared
	// inside break stays cleared
	always @(posedge mclk) begin
		if (srst) begin
			break_mode <= 1'b0;
		end else if (reset_any) begin
			break_mode <= 1'b0;
		end else if (state_q == ST_LATCH && vec_ack && lat_brk_q) begin
			break_mode <= 1'b1;
		end else if (ret_exec) begin
			break_mode <= 1'b0;
		end
	end

	// Two-step clear trackers, one per flag that needs the sequence
	genvar g;
	generate
		for (g = 0; g < `ECARB_NCLR2; g = g + 1) begin : g_clr2
			ecarb_clr2 u_clr2 (
				.mclk   (mclk),
				.srst   (srst),
				.step1  (clr_step1[g]),
				.step2  (clr_step2[g]),
				.permit (clear_permit),
				.fire   (clr_fire[g])
			);
		end
	endgenerate

	// Break flag control register: only the clear enable bit is stored.
	// Writes elsewhere, the status registers included, change nothing
	always @(posedge mclk) begin
		if (srst) begin
			clr_en_q <= `ECARB_BRKCTL_RST;
		end else if (bus_wr && bus_addr == `ECARB_ADDR_BRKCTL) begin
			clr_en_q <= bus_wdata[`ECARB_BRKCTL_CLREN_BIT];
		end
	end

	// Read multiplexer: status bits are the live pending flags, not copies,
	// so there is nothing for software to clear here
	always @* begin
		rd_mux = 8'h00;
		case (bus_addr)
			`ECARB_ADDR_BRKCTL: begin
				rd_mux[`ECARB_BRKCTL_CLREN_BIT] = clr_en_q;
			end
			`ECARB_ADDR_STAT_ONE: begin
				rd_mux = {1'b0, pend[6:1], 1'b0};
			end
			`ECARB_ADDR_STAT_TWO: begin
				rd_mux = {3'b000, pend[11:7]};
			end
			`ECARB_ADDR_STAT_THR: begin
				rd_mux = 8'h00;
			end
			default: begin
				rd_mux = 8'h00;
			end
		endcase
	end

	// Read data stands only in the cycle after the strobe
	always @(posedge mclk) begin
		if (srst) begin
			bus_rdata <= 8'h00;
		end else if (bus_rd) begin
			bus_rdata <= rd_mux;
		end else begin
			bus_rdata <= 8'h00;
		end
	end

endmodule // ecarb_top

// >>> core/ecarb_map.vh
/*
 * Constants of the exception control arbiter: register offsets, field
 * positions, reset values, source indices, priority and vector codes.
 * Assumes it is included by its bare name from the arbiter's design files.
 */
`ifndef ECARB_MAP_VH
`define ECARB_MAP_VH

// Register offsets on the 16-bit register port
`define ECARB_ADDR_BRKCTL    16'hfe03
`define ECARB_ADDR_STAT_ONE  16'hfe04
`define ECARB_ADDR_STAT_TWO  16'hfe05
`define ECARB_ADDR_STAT_THR  16'hfe06

// Field positions
`define ECARB_BRKCTL_CLREN_BIT 7
`define ECARB_BRKCTL_RST     1'b0

// Number of raw sources and of grouped pending flags
`define ECARB_NSRC           17
`define ECARB_NFLAG          11
`define ECARB_NCLR2          4

// Raw source indices (request and enable vectors)
`define ECARB_SRC_EXTPIN     0
`define ECARB_SRC_HUB_LO     1
`define ECARB_SRC_HUB_HI     4
`define ECARB_SRC_HEP0_LO    5
`define ECARB_SRC_HEP0_HI    6
`define ECARB_SRC_DEV_LO     7
`define ECARB_SRC_DEV_HI     9
`define ECARB_SRC_TCH0       10
`define ECARB_SRC_TCH1       11
`define ECARB_SRC_TOVF       12
`define ECARB_SRC_KEYE       13
`define ECARB_SRC_KEYD       14
`define ECARB_SRC_KEYF       15
`define ECARB_SRC_PLL        16

// Vector select codes: equal to the priority, zero is the highest
`define ECARB_VEC_SOFT       4'h0
`define ECARB_VEC_HUB        4'h2
`define ECARB_VEC_HEP0       4'h3
`define ECARB_VEC_DEV        4'h4
`define ECARB_VEC_KEYE       4'h8
`define ECARB_VEC_KEYD       4'h9
`define ECARB_VEC_KEYF       4'ha
`define ECARB_VEC_LAST       4'hb

// Vector pair base: code n fetches from base minus twice n
`define ECARB_VEC_BASE       16'hfffc

`endif

// >>> core/ecarb_clr2.v
/*
 * Two-step flag clear tracker for one peripheral flag.
 * Assumes first and second step strobes come from logic on mclk and that
 * the permit level is high outside break mode or when clearing is enabled.
 */
`timescale 1ns/1ns

module ecarb_clr2 (
	input  wire mclk,     // Bus clock
	input  wire srst,     // Synchronous reset, active high
	input  wire step1,    // First step of the clear sequence seen
	input  wire step2,    // Second step of the clear sequence seen
	input  wire permit,   // Clearing allowed now
	output reg  fire      // One-cycle pulse: clear the flag
);

	reg armed_q; // First step has happened, waiting for the second
	reg armed_d; // Next value of armed_q

	// Arm on the first step; a blocked second step keeps the arming so the
	// same step after break still clears
	always @* begin
		armed_d = armed_q;
		if (step2 && armed_q && permit) begin
			armed_d = 1'b0;
		end else if (step1) begin
			armed_d = 1'b1;
		end
	end

	// Registers: the clear pulse leaves from a flop
	always @(posedge mclk) begin
		if (srst) begin
			armed_q <= 1'b0;
			fire    <= 1'b0;
		end else begin
			armed_q <= armed_d;
			fire    <= step2 & armed_q & permit;
		end
	end

endmodule // ecarb_clr2

// >>> tb/ecarb_properties.sv
/* Port checker for the exception control arbiter.
   Assumes it is bound to ecarb_top and that everything runs on mclk. */
`timescale 1ns/1ns

module ecarb_chk (
	input wire        mclk,
	input wire        srst,
	input wire [15:0] bus_addr,
	input wire        bus_rd,
	input wire [7:0]  bus_rdata,
	input wire [16:0] src_flag,
	input wire [16:0] src_ie,
	input wire        instr_done,
	input wire        imask,
	input wire        sw_int_exec,
	input wire        ret_exec,
	input wire        vec_ack,
	input wire        brk_assert,
	input wire        reset_any,
	input wire        int_req,
	input wire [3:0]  vector_sel,
	input wire [15:0] vector_addr,
	input wire        push_pc_dec,
	input wire        push_h,
	input wire        set_imask,
	input wire        pop_regs,
	input wire        break_mode,
	input wire        clear_permit,
	input wire [3:0]  clr_fire
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (srst);
	// No boundary and no software or break request in flight
	sequence s_quiet;
		!int_req && !instr_done && !ret_exec && !sw_int_exec && !$past(sw_int_exec) && !brk_assert;
	endsequence
	// Software interrupt issued from idle, then left undisturbed
	sequence s_soft;
		sw_int_exec && !int_req && !instr_done && !ret_exec && !brk_assert && !reset_any
		##1 !reset_any && !brk_assert;
	endsequence
	// Core takes the vector
	sequence s_ack;
		int_req && vec_ack && !reset_any;
	endsequence
	a_vec_pair: assert property (vector_addr == 16'hfffc - {11'h000, vector_sel, 1'b0})
		else $error("vector address does not match select code");
	a_no_high_idx: assert property (push_h == 1'b0)
		else $error("high index register stacked");
	a_hw_entry: assert property (!int_req && instr_done && !imask && (src_flag & src_ie) != 17'h0
		&& !sw_int_exec && !$past(sw_int_exec) && !brk_assert && !reset_any && !$past(reset_any)
		|=> int_req && push_pc_dec)
		else $error("enabled request not taken at boundary");
	a_idle_hold: assert property (s_quiet |=> !int_req)
		else $error("entry started between boundaries");
	a_latch_hold: assert property (int_req && !vec_ack && !reset_any && $stable(imask)
		|=> int_req && $stable(vector_sel))
		else $error("latched request displaced");
	a_soft_entry: assert property (s_soft |=> int_req && vector_sel == 4'h0 && !push_pc_dec)
		else $error("software interrupt not taken");
	a_ack_mask: assert property (s_ack |=> !int_req && set_imask ##1 !set_imask)
		else $error("entry did not set mask once");
	a_ret_pop: assert property (ret_exec && !reset_any |=> pop_regs)
		else $error("return did not unstack");
	a_reset_wins: assert property (reset_any |=> !int_req)
		else $error("entry during reset");
	a_break_entry: assert property (brk_assert && instr_done && !int_req && !reset_any
		&& !$past(reset_any) |=> int_req && vector_sel == 4'h0 && !push_pc_dec)
		else $error("break did not force software vector");
	a_clear_guard: assert property (break_mode && !clear_permit |=> clr_fire == 4'h0)
		else $error("flag cleared while protected");
	a_stat_three: assert property (bus_rd && bus_addr == 16'hfe06 |=> bus_rdata == 8'h00)
		else $error("status three not zero");
endmodule // ecarb_chk

bind ecarb_top ecarb_chk u_chk (.*);

// >>> tb/ecarb_core_model.sv
/* Behavioural core: acknowledges entry requests after a chosen lag and
   keeps its mask bit. Assumes the arbiter's mclk and srst. */
`timescale 1ns/1ns

module ecarb_core_model (
	input  wire       mclk,
	input  wire       srst,
	input  wire       int_req,
	input  wire       set_imask,
	input  wire       pop_regs,
	input  wire [2:0] lag,
	output reg        vec_ack,
	output reg        imask
);
	reg [2:0] wait_q; // Cycles spent on the current request
	// Ack is a single pulse so one request is never taken twice
	always @(posedge mclk) begin
		if (srst) begin
			vec_ack <= 1'b0;
			wait_q  <= 3'h0;
			imask   <= 1'b1; // Core leaves reset masked
		end else begin
			vec_ack <= 1'b0;
			wait_q  <= 3'h0;
			if (int_req && !vec_ack) begin
				if (wait_q == lag) vec_ack <= 1'b1;
				else wait_q <= wait_q + 3'h1;
			end
			if (set_imask) imask <= 1'b1;
			else if (pop_regs) imask <= 1'b0;
		end
	end
endmodule // ecarb_core_model

// >>> tb/tb_exception_control_arbiter.sv
/* Self-checking bench of the arbiter with a core model.
   Assumes ecarb_top, ecarb_core_model and the bound checker. */
`timescale 1ns/1ns

module tb_exception_control_arbiter;
	logic        mclk, srst, bus_wr, bus_rd, instr_done, sw_int_exec, ret_exec, brk_assert;
	logic        reset_any;
	logic [15:0] bus_addr;
	logic [7:0]  bus_wdata;
	logic [16:0] src_flag, src_ie, f, e;
	logic [3:0]  clr_step1, clr_step2;
	logic [2:0]  lag;
	logic [11:0] g;                  // Expected grouped pending flags
	logic [31:0] r;                  // Random draw
	wire  [7:0]  bus_rdata;
	wire  [3:0]  vector_sel, clr_fire;
	wire  [15:0] vector_addr;
	wire         int_req, push_pc_dec, push_h, set_imask, pop_regs, break_mode;
	wire         clear_permit, vec_ack, imask;
	int          mismatches = 0, n_checks = 0, cycles = 0;

	ecarb_top u_dut (.*);
	ecarb_core_model u_core (.*);

	always #5 mclk = ~mclk;

	// Group n is the OR of its enabled sources
	function automatic logic [11:0] grp(input logic [16:0] p);
		grp = {p[16:10], |p[9:7], |p[6:5], |p[4:1], p[0], 1'b0};
	endfunction
	// Lowest set group number wins
	function automatic logic [3:0] top_code(input logic [11:0] q);
		top_code = 4'h0;
		for (int k = 11; k >= 1; k--) if (q[k]) top_code = k[3:0];
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge mclk);
		{bus_wr, bus_addr, bus_wdata} <= {1'b1, a, d};
		@(posedge mclk);
		bus_wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [15:0] a, input logic [7:0] x);
		@(posedge mclk);
		{bus_rd, bus_addr} <= {1'b1, a};
		@(posedge mclk);
		bus_rd <= 1'b0;
		#1 chk(bus_rdata, x);
	endtask
	// One-cycle core event: boundary, software interrupt, return
	task automatic core_ev(input logic [2:0] v);
		@(posedge mclk);
		{instr_done, sw_int_exec, ret_exec} <= v;
		@(posedge mclk);
		{instr_done, sw_int_exec, ret_exec} <= 3'h0;
	endtask
	task automatic clr(input logic [3:0] s1, input logic [3:0] s2, input logic [3:0] x);
		@(posedge mclk);
		{clr_step1, clr_step2} <= {s1, s2};
		@(posedge mclk);
		{clr_step1, clr_step2} <= 8'h00;
		#1 chk(clr_fire, x);
	endtask
	// Bounded wait for the entry request level
	task automatic wt(input logic v);
		int n;
		n = 0;
		#1;
		while (int_req !== v && n < 40) begin
			@(posedge mclk);
			#1 n++;
		end
		chk(int_req, v);
	endtask
	// Return, then give the mask time to drop
	task automatic leave();
		core_ev(3'b001);
		repeat (3) @(posedge mclk);
	endtask

	// Hang guard
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			give_verdict();
		end
	end

	initial begin
		{mclk, srst, bus_wr, bus_rd, instr_done, sw_int_exec, ret_exec, brk_assert} = 8'h40;
		{reset_any, bus_addr, bus_wdata, src_flag, src_ie, clr_step1, clr_step2, lag} = '0;
		r = $urandom(32'he9ee);
		repeat (8) @(posedge mclk);
		srst <= 1'b0;
		#1 chk(vector_addr, 16'hfffc);
		chk(clear_permit, 1'b1);
		chk(push_h, 1'b0);
		rd(16'hfe03, 8'h00);
		rd(16'h1234, 8'h00);
		leave();
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			r = $urandom;
			f = (i == 0) ? 17'h1ffff : (i == 1) ? 17'h10000 : r[16:0];
			r = $urandom;
			e = (i < 2) ? 17'h1ffff : (i == 2) ? 17'h0 : r[16:0];
			g = grp(f & e);
			@(posedge mclk);
			{src_flag, src_ie, lag} <= {f, e, r[31:29]};
			rd(16'hfe04, {1'b0, g[6:1], 1'b0});
			wr(16'hfe05, 8'hff);
			rd(16'hfe05, {3'h0, g[11:7]});
			rd(16'hfe06, 8'h00);
			core_ev(3'b100);
			if (g == 12'h0) begin
				#1 chk(int_req, 1'b0);
			end else begin
				wt(1'b1);
				chk(vector_sel, top_code(g));
				chk(vector_addr, 16'hfffc - {11'h0, top_code(g), 1'b0});
				chk(push_pc_dec, 1'b1);
				@(posedge mclk);
				{src_flag, src_ie} <= {17'h1ffff, 17'h1ffff};
				@(posedge mclk);
				#1 chk(vector_sel, top_code(g));
				wt(1'b0);
				repeat (3) @(posedge mclk);
				core_ev(3'b100);
				#1 chk(int_req, 1'b0);
				core_ev(3'b010);
				wt(1'b1);
				chk(vector_sel, 4'h0);
				chk(push_pc_dec, 1'b0);
				wt(1'b0);
				leave();
				core_ev(3'b100);
				wt(1'b1);
				chk(vector_sel, 4'h1);
				wt(1'b0);
				leave();
			end
		end
		$display("test arbitration done");
		clr(4'h1, 4'h0, 4'h0);
		@(posedge mclk) brk_assert <= 1'b1;
		core_ev(3'b100);
		wt(1'b1);
		chk(vector_sel, 4'h0);
		wt(1'b0);
		@(posedge mclk) brk_assert <= 1'b0;
		#1 chk(break_mode, 1'b1);
		chk(clear_permit, 1'b0);
		clr(4'h0, 4'h1, 4'h0);
		wr(16'hfe03, 8'h80);
		rd(16'hfe03, 8'h80);
		chk(clear_permit, 1'b1);
		clr(4'h2, 4'h0, 4'h0);
		clr(4'h0, 4'h2, 4'h2);
		wr(16'hfe03, 8'h00);
		leave();
		chk(break_mode, 1'b0);
		clr(4'h0, 4'h3, 4'h1);
		$display("test break done");
		@(posedge mclk) reset_any <= 1'b1;
		core_ev(3'b100);
		#1 chk(int_req, 1'b0);
		@(posedge mclk) reset_any <= 1'b0;
		$display("test reset source done");
		give_verdict();
	end
endmodule // tb_exception_control_arbiter
